// >>> verilog/sadc_pkg.sv
// Package: register map, field layout, reset values and timing constants of the converter sequencer
package sadc_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_TIMING = 8'h08;
   localparam logic [7:0] OFS_RES_HIGH = 8'h0C;
   localparam logic [7:0] OFS_RES_LOW = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL0_ENABLE_BIT = 0;
   localparam int CTRL0_GO_BIT = 1;
   localparam int CTRL0_CHAN_LSB = 2;
   localparam int CTRL1_POS_REF_BIT = 4;
   localparam int CTRL1_NEG_REF_BIT = 5;
   localparam int TIMING_CLK_LSB = 0;
   localparam int TIMING_ACQ_LSB = 3;
   localparam int TIMING_JUSTIFY_BIT = 7;
   localparam int FLAGS_DONE_BIT = 0;
   localparam int FLAGS_IRQ_EN_BIT = 1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [1:0] RST_FLAGS = 2'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   // One instruction cycle is four oscillator periods
   localparam int INSTR_CYCLE_PS = 4 * CLK_PERIOD_PS;
   localparam int INSTR_CYCLES = (INSTR_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CONV_TADS = 11;
   localparam int POST_WAIT_TADS = 2;
   localparam int RESULT_BITS = 10;

   localparam logic [2:0] ACQ_NONE = 3'h0;

   typedef enum logic [2:0] {
      SADC_IDLE = 3'b000,
      SADC_ACQ = 3'b001,
      SADC_CONV = 3'b010,
      SADC_WAIT = 3'b011
   } sadc_state_t;

endpackage

// >>> verilog/sadc_sequencer.sv
// Module: converter sequencer with AHB-Lite register slave and successive-approximation control
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Result format bit set gives right-justified result, clear gives left-justified.
// - Acquisition field decodes to 0,2,4,6,8,12,16,20 conversion-clock periods.
// - Clock field selects sysclk/2,/8,/32,/4,/16,/64, or the local RC clock.
// - RC clock source waits one instruction cycle before conversion clock runs.
// - Software picks reference as supply rails or dedicated reference pins.
// - Conversion continues in sleep only when the RC clock is selected.
// - Result found by successive approximation, one bit per conversion-clock period.
// - Any reset clears control and flag registers, disables converter, aborts conversion.
// - Completion loads result, clears start/busy bit, sets done flag.
// - Result registers keep their content across reset; undefined at power-up.
// - Nonzero acquisition field: sample programmed periods after start, then convert.
// - Acquisition field zero: start stops sampling and converts at once.
// - After each conversion sampling of the selected channel resumes by itself.
// - Busy bit stays set through acquisition and conversion, no phase indication.
// - One 10-bit conversion takes eleven conversion-clock periods.
// - At least two conversion-clock periods pass after conversion before acquisition.
// - Holding capacitor disconnected from input from conversion start to its end.
// - Enable bit gates all operation; channel field selects inputs 0 to 10.
// - Reference select bits choose pin or supply for negative and positive reference.
// - Clearing busy bit mid-conversion aborts; result keeps last completed or written value.
module sadc_sequencer #(
   parameter int RESULT_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic local_rc_clock,
   input wire logic sys_sleep,
   input wire logic comp_high,
   output logic sample_en,
   output logic trial_strobe,
   output logic [RESULT_W-1:0] trial_code,
   output logic [3:0] channel_sel,
   output logic neg_ref_sel,
   output logic pos_ref_sel,
   output logic converter_enable,
   output logic conv_done_flag
);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic [4:0] acq_tads(input logic [2:0] sel);
      case (sel)
         3'h1: acq_tads = 5'h02;
         3'h2: acq_tads = 5'h04;
         3'h3: acq_tads = 5'h06;
         3'h4: acq_tads = 5'h08;
         3'h5: acq_tads = 5'h0C;
         3'h6: acq_tads = 5'h10;
         3'h7: acq_tads = 5'h14;
         default: acq_tads = 5'h00;
      endcase
   endfunction

   // Sysclk periods per conversion-clock period; zero means RC source
   function automatic logic [6:0] clk_div(input logic [2:0] sel);
      case (sel)
         3'h0: clk_div = 7'h02;
         3'h1: clk_div = 7'h08;
         3'h2: clk_div = 7'h20;
         3'h4: clk_div = 7'h04;
         3'h5: clk_div = 7'h10;
         3'h6: clk_div = 7'h40;
         default: clk_div = 7'h00;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic go_busy;
   logic neg_ref;
   logic pos_ref;
   logic right_justify;
   logic [2:0] acq_time_sel;
   logic [2:0] conv_clk_sel;
   logic irq_en;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic [3:0] chan;
   logic enable;
   logic done_flag;

   sadc_pkg::sadc_state_t state;
   logic [4:0] tad_cnt;
   logic [6:0] div_cnt;
   logic [2:0] rc_hold;
   logic tick;
   logic [RESULT_W-1:0] sar;
   logic [RESULT_W-1:0] trial_bit;
   logic [RESULT_W-1:0] sar_final;
   logic conv_end;
   logic abort;
   logic start;

   // ------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ------------------------------------------------------------
   logic dp_write;
   logic [7:0] dp_addr;
   logic ap_valid;
   logic [7:0] rd_mux;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_timing;
   logic wr_res_high;
   logic wr_res_low;
   logic wr_flags;

   assign ap_valid = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_write <= ap_valid & hwrite;
         dp_addr <= haddr;
      end
   end

   assign wr_ctrl0 = dp_write && dp_addr == sadc_pkg::OFS_CTRL0;
   assign wr_ctrl1 = dp_write && dp_addr == sadc_pkg::OFS_CTRL1;
   assign wr_timing = dp_write && dp_addr == sadc_pkg::OFS_TIMING;
   assign wr_res_high = dp_write && dp_addr == sadc_pkg::OFS_RES_HIGH;
   assign wr_res_low = dp_write && dp_addr == sadc_pkg::OFS_RES_LOW;
   assign wr_flags = dp_write && dp_addr == sadc_pkg::OFS_FLAGS;

   // Read data chosen in the address phase, presented from flops in the data phase
   always_comb begin
      case (haddr)
         sadc_pkg::OFS_CTRL0: rd_mux = {2'h0, chan, go_busy, enable};
         sadc_pkg::OFS_CTRL1: rd_mux = {2'h0, neg_ref, pos_ref, 4'h0};
         sadc_pkg::OFS_TIMING: rd_mux = {right_justify, 1'b0, acq_time_sel, conv_clk_sel};
         sadc_pkg::OFS_RES_HIGH: rd_mux = result_high_byte;
         sadc_pkg::OFS_RES_LOW: rd_mux = result_low_byte;
         sadc_pkg::OFS_FLAGS: rd_mux = {6'h00, irq_en, done_flag};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         hrdata <= {24'h00_0000, rd_mux};
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable <= sadc_pkg::RST_CTRL0[sadc_pkg::CTRL0_ENABLE_BIT];
         chan <= sadc_pkg::RST_CTRL0[sadc_pkg::CTRL0_CHAN_LSB +: 4];
      end else if (wr_ctrl0) begin
         enable <= hwdata[sadc_pkg::CTRL0_ENABLE_BIT];
         chan <= hwdata[sadc_pkg::CTRL0_CHAN_LSB +: 4];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         neg_ref <= sadc_pkg::RST_CTRL1[sadc_pkg::CTRL1_NEG_REF_BIT];
         pos_ref <= sadc_pkg::RST_CTRL1[sadc_pkg::CTRL1_POS_REF_BIT];
      end else if (wr_ctrl1) begin
         neg_ref <= hwdata[sadc_pkg::CTRL1_NEG_REF_BIT];
         pos_ref <= hwdata[sadc_pkg::CTRL1_POS_REF_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         right_justify <= sadc_pkg::RST_TIMING[sadc_pkg::TIMING_JUSTIFY_BIT];
         acq_time_sel <= sadc_pkg::RST_TIMING[sadc_pkg::TIMING_ACQ_LSB +: 3];
         conv_clk_sel <= sadc_pkg::RST_TIMING[sadc_pkg::TIMING_CLK_LSB +: 3];
      end else if (wr_timing) begin
         right_justify <= hwdata[sadc_pkg::TIMING_JUSTIFY_BIT];
         acq_time_sel <= hwdata[sadc_pkg::TIMING_ACQ_LSB +: 3];
         conv_clk_sel <= hwdata[sadc_pkg::TIMING_CLK_LSB +: 3];
      end
   end

   // Start/busy bit: a start written together with the enable is ignored
   assign start = wr_ctrl0 && hwdata[sadc_pkg::CTRL0_GO_BIT] && enable && !go_busy;
   assign abort = go_busy && ((wr_ctrl0 && !hwdata[sadc_pkg::CTRL0_GO_BIT]) || !enable);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_busy <= sadc_pkg::RST_CTRL0[sadc_pkg::CTRL0_GO_BIT];
      end else if (conv_end || abort) begin
         go_busy <= 1'b0;
      end else if (start) begin
         go_busy <= 1'b1;
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_flag <= sadc_pkg::RST_FLAGS[sadc_pkg::FLAGS_DONE_BIT];
         irq_en <= sadc_pkg::RST_FLAGS[sadc_pkg::FLAGS_IRQ_EN_BIT];
      end else begin
         if (conv_end) begin
            done_flag <= 1'b1;
         end else if (wr_flags) begin
            done_flag <= hwdata[sadc_pkg::FLAGS_DONE_BIT];
         end
         if (wr_flags) begin
            irq_en <= hwdata[sadc_pkg::FLAGS_IRQ_EN_BIT];
         end
      end
   end

   // Result pair has no reset on purpose: content survives any reset
   always_ff @(posedge hclk) begin
      if (conv_end) begin
         if (right_justify) begin
            result_high_byte <= {6'h00, sar_final[9:8]};
            result_low_byte <= sar_final[7:0];
         end else begin
            result_high_byte <= sar_final[9:2];
            result_low_byte <= {sar_final[1:0], 6'h00};
         end
      end else begin
         if (wr_res_high) begin
            result_high_byte <= hwdata[7:0];
         end
         if (wr_res_low) begin
            result_low_byte <= hwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Conversion clock
   // ------------------------------------------------------------
   logic rc_meta;
   logic rc_sync;
   logic rc_prev;
   logic rc_src;
   logic [6:0] div_n;

   assign div_n = clk_div(conv_clk_sel);
   assign rc_src = div_n == 7'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rc_meta <= 1'b0;
         rc_sync <= 1'b0;
         rc_prev <= 1'b0;
      end else begin
         rc_meta <= local_rc_clock;
         rc_sync <= rc_meta;
         rc_prev <= rc_sync;
      end
   end

   // Divider restarts at each start so the first period is whole
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 7'h00;
         rc_hold <= 3'h0;
      end else if (state == sadc_pkg::SADC_IDLE) begin
         div_cnt <= 7'h00;
         rc_hold <= 3'(sadc_pkg::INSTR_CYCLES);
      end else begin
         if (rc_hold != 3'h0) begin
            rc_hold <= rc_hold - 3'h1;
         end
         // System divider halts while asleep; only the RC source keeps running
         if (!sys_sleep) begin
            div_cnt <= (div_cnt == div_n - 7'h01) ? 7'h00 : div_cnt + 7'h01;
         end
      end
   end

   always_comb begin
      if (state == sadc_pkg::SADC_IDLE) begin
         tick = 1'b0;
      end else if (rc_src) begin
         tick = rc_hold == 3'h0 && rc_sync && !rc_prev;
      end else begin
         tick = !sys_sleep && div_cnt == div_n - 7'h01;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   assign conv_end = state == sadc_pkg::SADC_CONV && tick && !abort &&
      tad_cnt == 5'(sadc_pkg::CONV_TADS - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= sadc_pkg::SADC_IDLE;
         tad_cnt <= 5'h00;
      end else if (!enable) begin
         state <= sadc_pkg::SADC_IDLE;
         tad_cnt <= 5'h00;
      end else begin
         case (state)
            sadc_pkg::SADC_IDLE: begin
               tad_cnt <= 5'h00;
               // A start written during the post-conversion wait is taken here
               if (start || go_busy) begin
                  if (acq_time_sel == sadc_pkg::ACQ_NONE) begin
                     state <= sadc_pkg::SADC_CONV;
                  end else begin
                     state <= sadc_pkg::SADC_ACQ;
                  end
               end
            end
            sadc_pkg::SADC_ACQ: begin
               if (abort) begin
                  state <= sadc_pkg::SADC_WAIT;
                  tad_cnt <= 5'h00;
               end else if (tick) begin
                  if (tad_cnt == acq_tads(acq_time_sel) - 5'h01) begin
                     state <= sadc_pkg::SADC_CONV;
                     tad_cnt <= 5'h00;
                  end else begin
                     tad_cnt <= tad_cnt + 5'h01;
                  end
               end
            end
            sadc_pkg::SADC_CONV: begin
               if (abort || conv_end) begin
                  state <= sadc_pkg::SADC_WAIT;
                  tad_cnt <= 5'h00;
               end else if (tick) begin
                  tad_cnt <= tad_cnt + 5'h01;
               end
            end
            sadc_pkg::SADC_WAIT: begin
               if (tick) begin
                  if (tad_cnt == 5'(sadc_pkg::POST_WAIT_TADS - 1)) begin
                     state <= sadc_pkg::SADC_IDLE;
                     tad_cnt <= 5'h00;
                  end else begin
                     tad_cnt <= tad_cnt + 5'h01;
                  end
               end
            end
            default: begin
               state <= sadc_pkg::SADC_IDLE;
               tad_cnt <= 5'h00;
            end
         endcase
      end
   end

   // Last decision must join the word in the same edge that loads the result
   assign sar_final = comp_high ? (sar | trial_bit) : sar;

   // Successive approximation: first period settles, then one bit per period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sar <= '0;
         trial_bit <= '0;
         trial_code <= '0;
         trial_strobe <= 1'b0;
      end else begin
         trial_strobe <= 1'b0;
         if (state != sadc_pkg::SADC_CONV) begin
            sar <= '0;
            trial_bit <= '0;
         end else if (tick && !abort) begin
            if (tad_cnt == 5'h00) begin
               trial_bit <= {1'b1, {(RESULT_W-1){1'b0}}};
               trial_code <= {1'b1, {(RESULT_W-1){1'b0}}};
               trial_strobe <= 1'b1;
            end else begin
               if (comp_high) begin
                  sar <= sar | trial_bit;
               end
               trial_bit <= trial_bit >> 1;
               if (trial_bit[0] == 1'b0) begin
                  trial_code <= sar_final | (trial_bit >> 1);
                  trial_strobe <= 1'b1;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Hold capacitor tracks the input only while idle or acquiring
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_en <= 1'b0;
      end else begin
         sample_en <= enable && (next_sampling(state, start || go_busy, acq_time_sel));
      end
   end

   function automatic logic next_sampling(input sadc_pkg::sadc_state_t st, input logic go,
      input logic [2:0] acq);
      next_sampling = (st == sadc_pkg::SADC_IDLE && !(go && acq == sadc_pkg::ACQ_NONE)) ||
         st == sadc_pkg::SADC_ACQ;
   endfunction

   assign channel_sel = chan;
   assign neg_ref_sel = neg_ref;
   assign pos_ref_sel = pos_ref;
   assign converter_enable = enable;
   assign conv_done_flag = done_flag;

endmodule

`default_nettype wire

// >>> testbench/sadc_sequencer_props.sv
// Checker: port timing relations of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sadc_sequencer_props #(
   parameter int RESULT_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sample_en,
   input wire logic trial_strobe,
   input wire logic [RESULT_W-1:0] trial_code,
   input wire logic converter_enable,
   input wire logic conv_done_flag
);
   // ------
   // Trials since sampling stopped
   // ------
   logic [3:0] n_trial;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         n_trial <= 4'h0;
      end else if (sample_en) begin
         n_trial <= 4'h0;
      end else if (trial_strobe) begin
         n_trial <= n_trial + 4'h1;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_first;
      trial_strobe && n_trial == 4'h0;
   endsequence
   sequence s_next;
      trial_strobe && n_trial != 4'h0;
   endsequence
   sequence s_done;
      $rose(conv_done_flag);
   endsequence
   a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1 && hrdata[31:8] == 24'h0)
      else $error("bus response or read data upper bits wrong");
   a_strobe_pulse: assert property (trial_strobe |=> !trial_strobe)
      else $error("trial strobe longer than one cycle");
   a_hold_open: assert property (trial_strobe |-> !sample_en)
      else $error("hold capacitor connected during a trial");
   a_first_trial: assert property (s_first |-> trial_code == (1 << (RESULT_W - 1)))
      else $error("first trial code is not mid scale");
   a_trial_bit: assert property (s_next |-> trial_code[RESULT_W - 1 - n_trial] == 1'b1)
      else $error("trial code misses the bit under test");
   a_trial_count: assert property (s_done |-> n_trial == 4'hA)
      else $error("conversion did not take ten trials");
   a_trial_limit: assert property (n_trial <= 4'hA)
      else $error("more than ten trials in one conversion");
   a_post_wait: assert property (s_done |-> (!sample_en) [*3])
      else $error("sampling resumed too soon after conversion");
   a_auto_resample: assert property (s_done |-> ##[1:600] sample_en)
      else $error("sampling did not resume after conversion");
   a_off_quiet: assert property ((!converter_enable) [*2] |-> !trial_strobe)
      else $error("trial while converter disabled");
endmodule
bind sadc_sequencer sadc_sequencer_props #(.RESULT_W(RESULT_W)) u_props (
   .hclk(hclk),
   .hresetn(hresetn),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .sample_en(sample_en),
   .trial_strobe(trial_strobe),
   .trial_code(trial_code),
   .converter_enable(converter_enable),
   .conv_done_flag(conv_done_flag)
);
`default_nettype wire

// >>> testbench/sadc_core_model.sv
// Behavioural sample-and-hold and comparator core
`timescale 1ns/100ps
`default_nettype none
module sadc_core_model (
   input wire logic hclk,
   input wire logic sample_en,
   input wire logic [9:0] trial_code,
   input wire logic [9:0] vin,
   output logic comp_high
);
   logic [9:0] held = 10'h000;
   initial comp_high = 1'b0;
   // Toggles while sampling so a stale comparison is never trusted
   always @(posedge hclk) begin
      if (sample_en) begin
         held <= vin;
      end
      comp_high <= sample_en ? ~comp_high : (held >= trial_code);
   end
endmodule
`default_nettype wire

// >>> testbench/test_sar_adc_sequencer.sv
// Testbench: registers, conversions, abort and reset of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_sequencer;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic local_rc_clock = 1'b0;
   logic sys_sleep = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h00000000;
   logic [9:0] vin = 10'h000;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, comp_high, sample_en, trial_strobe;
   wire logic neg_ref_sel, pos_ref_sel, converter_enable, conv_done_flag;
   wire logic [9:0] trial_code;
   wire logic [3:0] channel_sel;
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'h9272;
   int div_tab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   logic [9:0] last_v;
   logic last_rj;
   always #2.5 hclk = ~hclk;
   // Free-running, period unrelated to hclk
   always #23.5 local_rc_clock = ~local_rc_clock;
   sadc_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .local_rc_clock(local_rc_clock),
      .sys_sleep(sys_sleep), .comp_high(comp_high), .sample_en(sample_en),
      .trial_strobe(trial_strobe), .trial_code(trial_code), .channel_sel(channel_sel),
      .neg_ref_sel(neg_ref_sel), .pos_ref_sel(pos_ref_sel),
      .converter_enable(converter_enable), .conv_done_flag(conv_done_flag));
   sadc_core_model core (.hclk(hclk), .sample_en(sample_en), .trial_code(trial_code),
      .vin(vin), .comp_high(comp_high));
   // ------
   // Checking and bus tasks
   // ------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(what, exp, x);
   endtask
   function automatic logic [31:0] res_hi(input logic [9:0] v, input logic rj);
      return rj ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
   endfunction
   function automatic logic [31:0] res_lo(input logic [9:0] v, input logic rj);
      return rj ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
   endfunction
   task automatic convert(input logic [2:0] cs, input logic [2:0] aq, input logic rj,
      input logic [9:0] v, input logic [3:0] ch);
      int n, t, ns, first, last, acq_n;
      n = div_tab[cs];
      ns = 0;
      first = 0;
      last = 0;
      acq_n = 0;
      vin <= v;
      sys_sleep <= (n == 0);
      wr(sadc_pkg::OFS_TIMING, {24'h0, rj, 1'b0, aq, cs});
      wr(sadc_pkg::OFS_FLAGS, 32'h0);
      wr(sadc_pkg::OFS_CTRL0, {26'h0, ch, 2'b11});
      for (t = 0; t < 4000 && conv_done_flag !== 1'b1; t++) begin
         @(posedge hclk);
         acq_n += (sample_en === 1'b1);
         if (trial_strobe === 1'b1) begin
            first = (ns == 0) ? t : first;
            last = t;
            ns++;
         end
      end
      chk_rng("trials", 10, 10, ns);
      if (n != 0) begin
         chk_rng("trial span", 9 * n, 9 * n, last - first);
         chk_rng("acq cycles", (acq_tab[aq] - 1) * n,
            (aq == 3'h0) ? 1 : (acq_tab[aq] + 1) * n + 1, acq_n);
      end
      for (t = 0; t < 800 && sample_en !== 1'b1; t++) @(posedge hclk);
      if (n != 0) chk_rng("post wait", 2 * n - 1, 2 * n + 2, t);
      chk("channel", {28'h0, ch}, {28'h0, channel_sel});
      chk("resample", 32'h1, {31'h0, sample_en});
      sys_sleep <= 1'b0;
      rdchk(sadc_pkg::OFS_CTRL0, {26'h0, ch, 2'b01}, "busy clear");
      rdchk(sadc_pkg::OFS_FLAGS, 32'h1, "done flag");
      rdchk(sadc_pkg::OFS_RES_HIGH, res_hi(v, rj), "result high");
      rdchk(sadc_pkg::OFS_RES_LOW, res_lo(v, rj), "result low");
      last_v = v;
      last_rj = rj;
   endtask
   // ------
   // Main sequence
   // ------
   initial begin
      logic [31:0] rv;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(sadc_pkg::OFS_CTRL0, 32'h0, "ctrl0 reset");
      rdchk(sadc_pkg::OFS_TIMING, 32'h0, "timing reset");
      rdchk(sadc_pkg::OFS_FLAGS, 32'h0, "flags reset");
      wr(sadc_pkg::OFS_CTRL0, 32'h3);
      rdchk(sadc_pkg::OFS_CTRL0, 32'h1, "go with enable");
      wr(sadc_pkg::OFS_CTRL1, 32'h30);
      rdchk(sadc_pkg::OFS_CTRL1, 32'h30, "ctrl1");
      chk("refs", 32'h3, {30'h0, neg_ref_sel, pos_ref_sel});
      wr(8'h18, 32'hFFFFFFFF);
      rdchk(8'h18, 32'h0, "unmapped");
      for (int i = 0; i < 8; i++) begin
         rv = $random(seed);
         if (i == 0) rv[13:0] = 14'h3FF0;
         if (i == 1) rv[13:0] = 14'h0007;
         convert(3'(i), rv[2:0], rv[3], rv[13:4], 4'(rv[17:14] % 4'hB));
      end
      vin <= ~last_v;
      wr(sadc_pkg::OFS_TIMING, 32'h06);
      wr(sadc_pkg::OFS_FLAGS, 32'h0);
      wr(sadc_pkg::OFS_CTRL0, 32'h3);
      repeat (100) @(posedge hclk);
      wr(sadc_pkg::OFS_CTRL0, 32'h1);
      rdchk(sadc_pkg::OFS_CTRL0, 32'h1, "abort busy");
      rdchk(sadc_pkg::OFS_FLAGS, 32'h0, "abort flag");
      rdchk(sadc_pkg::OFS_RES_HIGH, res_hi(last_v, last_rj), "abort result");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk("enable", 32'h0, {31'h0, converter_enable});
      rdchk(sadc_pkg::OFS_CTRL1, 32'h0, "ctrl1 reset");
      rdchk(sadc_pkg::OFS_RES_LOW, res_lo(last_v, last_rj), "result kept");
      print_verdict;
   end
   // Eight conversions at most 2500 cycles each; ample margin
   initial begin
      #200000;
      n_fail++;
      print_verdict;
   end
endmodule
`default_nettype wire
